// >>> hw/jtl_link_timing.sv
// Serial lane sequencer: sync, delay, code group sync, data and wake-up.
`timescale 1ns/10ps
`default_nettype none
`include "jtl_cfg.svh"

// Overview of operation
// - Each sample travels as twenty line bits.
// - Subclass 0: K.28 five multiframes after request.
// - Subclass 1: K.28 six multiframes after SYSREF.
// - Code group sync lasts one multiframe minimum.
// - Lane latency 36 cycles, fast detect 7.
// - Wake within 250 us, standby 10 us.
// - Output power-down wake within 50 us.

module jtl_link_timing #(
  parameter int unsigned WAKE_ADC_CYC = `JTL_WAKE_ADC_US * `JTL_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic subclass1_in,
  input wire logic link_sync_request_n_in,
  input wire logic sysref_in,
  input wire logic adc_powerdown_in,
  input wire logic standby_in,
  input wire logic output_powerdown_in,
  input wire logic [`JTL_SMP_W-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic fd_in,
  output logic fd_out,
  output logic [`JTL_LANE_W-1:0] lane_word_out,
  output logic lane_valid_out,
  input wire logic lane_ready_in,
  output logic lane_enable_out,
  output logic link_active_out
);

  localparam int DLY = `JTL_LANE_LAT - 1;
  localparam int unsigned MF = `JTL_MF_CYC;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [`JTL_PIN_N-1:0] pin_s1_ff; // First stage, read only by the second.
  logic [`JTL_PIN_N-1:0] pin_s2_ff; // Safe copy of the pins.
  logic sysref_prev_ff; // Last sample of SYSREF for edge finding.
  logic sync_prev_ff; // Last sample of the sync request.
  logic sync_n_s; // Synchronised sync request, low asks for resync.
  logic sysref_s; // Synchronised SYSREF.
  logic any_pd; // Some power-down or standby mode is active.

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_s1_ff <= {1'h1, {(`JTL_PIN_N-1){1'h0}}};
      pin_s2_ff <= {1'h1, {(`JTL_PIN_N-1){1'h0}}};
      sysref_prev_ff <= 1'h0;
      sync_prev_ff <= 1'h1;
    end
    else
    begin
      pin_s1_ff <= {link_sync_request_n_in, sysref_in, adc_powerdown_in, standby_in, output_powerdown_in};
      pin_s2_ff <= pin_s1_ff;
      sysref_prev_ff <= pin_s2_ff[3];
      sync_prev_ff <= pin_s2_ff[4];
    end
  end

  assign sync_n_s = pin_s2_ff[4];
  assign sysref_s = pin_s2_ff[3];
  assign any_pd = pin_s2_ff[2] || pin_s2_ff[1] || pin_s2_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // Link state machine.
  jtl_pkg::jtl_state_t state_ff; // Present link state.
  jtl_pkg::jtl_state_t nxt_state; // State for the next clock.
  logic [15:0] phase_cnt_ff; // Clocks spent in the present state.
  logic [15:0] wake_cnt_ff; // Clocks left before wake-up ends.
  logic [15:0] dly_len; // Delay before the first K.28 word.
  logic sysref_rise; // Rising edge of SYSREF.

  assign sysref_rise = sysref_s && !sysref_prev_ff;
  assign dly_len = subclass1_in ? 16'(`JTL_SUB1_DELAY_MF * MF) : 16'(`JTL_SUB0_DELAY_MF * MF);

  // Next state; any power mode wins over the link sequence.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      jtl_pkg::JTL_ST_WAKE:
      begin
        // Restart the sequence only once wake-up time has run out.
        if (wake_cnt_ff == 16'h0000)
        begin
          nxt_state = jtl_pkg::JTL_ST_SYNC;
        end
      end
      jtl_pkg::JTL_ST_SYNC:
      begin
        // Subclass 1 waits for SYSREF, subclass 0 for a low request.
        if (subclass1_in ? sysref_rise : !sync_n_s)
        begin
          nxt_state = jtl_pkg::JTL_ST_DELAY;
        end
      end
      jtl_pkg::JTL_ST_DELAY:
      begin
        // Nothing valid is sent until the full delay has passed.
        if (phase_cnt_ff >= dly_len - 16'h0001)
        begin
          nxt_state = jtl_pkg::JTL_ST_CGS;
        end
      end
      jtl_pkg::JTL_ST_CGS:
      begin
        // Leave only after a whole multiframe of K.28 and a released request.
        if ((phase_cnt_ff >= 16'(`JTL_CGS_MIN_MF * MF - 1)) && sync_n_s)
        begin
          nxt_state = jtl_pkg::JTL_ST_DATA;
        end
      end
      jtl_pkg::JTL_ST_DATA:
      begin
        // A new low request restarts synchronization.
        if (!sync_n_s)
        begin
          nxt_state = jtl_pkg::JTL_ST_SYNC;
        end
      end
      default:
      begin
        nxt_state = jtl_pkg::JTL_ST_SYNC;
      end
    endcase
    if (any_pd)
    begin
      nxt_state = jtl_pkg::JTL_ST_WAKE;
    end
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= jtl_pkg::JTL_ST_SYNC;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Clocks in the present state; cleared on every change of state.
  always_ff @(posedge clk_in)
  begin
    if (rst_in || (nxt_state != state_ff))
    begin
      phase_cnt_ff <= 16'h0000;
    end
    else if (phase_cnt_ff != 16'hffff)
    begin
      phase_cnt_ff <= phase_cnt_ff + 16'h0001;
    end
  end

  // Wake-up timer reloads while a mode is held and runs down after release.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wake_cnt_ff <= 16'h0000;
    end
    else if (pin_s2_ff[2])
    begin
      wake_cnt_ff <= 16'(WAKE_ADC_CYC);
    end
    else if (pin_s2_ff[0])
    begin
      wake_cnt_ff <= 16'(`JTL_WAKE_OUT_CYC);
    end
    else if (pin_s2_ff[1])
    begin
      wake_cnt_ff <= 16'(`JTL_WAKE_STBY_CYC);
    end
    else if (wake_cnt_ff != 16'h0000)
    begin
      wake_cnt_ff <= wake_cnt_ff - 16'h0001;
    end
  end

  // Lane driver and link status flops.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      lane_enable_out <= 1'h1;
      link_active_out <= 1'h0;
    end
    else
    begin
      lane_enable_out <= !pin_s2_ff[0];
      link_active_out <= (nxt_state == jtl_pkg::JTL_ST_DATA);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample and fast detect pipelines.
  logic [`JTL_SMP_W-1:0] smp_dly_ff [DLY]; // Sample delay line.
  logic vld_dly_ff [DLY]; // Valid bit beside each stage.
  logic fd_dly_ff [`JTL_FD_LAT]; // Fast detect delay line.
  logic adv; // Pipeline may move; low while the buffer is full.
  logic buf_ready; // Buffer has room.
  logic buf_valid; // Valid of the word offered to the buffer.
  logic [`JTL_LANE_W-1:0] buf_word; // Word offered to the buffer.

  assign adv = buf_ready;
  assign sample_ready_out = buf_ready;

  // Stall of the receiver holds every sample stage, so no word is lost; the fast detect line keeps shifting.
  generate
    for (genvar i = 0; i < DLY; i++)
    begin : g_smp
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          smp_dly_ff[i] <= '0;
          vld_dly_ff[i] <= 1'h0;
        end
        else if (adv)
        begin
          smp_dly_ff[i] <= (i == 0) ? sample_in : smp_dly_ff[(i == 0) ? 0 : i-1];
          vld_dly_ff[i] <= (i == 0) ? sample_valid_in : vld_dly_ff[(i == 0) ? 0 : i-1];
        end
      end
    end
    for (genvar j = 0; j < `JTL_FD_LAT; j++)
    begin : g_fd
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          fd_dly_ff[j] <= 1'h0;
        end
        else
        begin
          fd_dly_ff[j] <= (j == 0) ? fd_in : fd_dly_ff[(j == 0) ? 0 : j-1];
        end
      end
    end
  endgenerate

  assign fd_out = fd_dly_ff[`JTL_FD_LAT-1];

  // Two ten-bit symbols per sample: K.28 during sync, sample octets after.
  always_comb
  begin
    buf_valid = 1'h0;
    buf_word = {`JTL_TAG_K, `JTL_K28_OCTET, `JTL_TAG_K, `JTL_K28_OCTET};
    if (state_ff == jtl_pkg::JTL_ST_CGS)
    begin
      buf_valid = 1'h1;
    end
    else if (state_ff == jtl_pkg::JTL_ST_DATA)
    begin
      buf_valid = vld_dly_ff[DLY-1];
      buf_word = {`JTL_TAG_D, smp_dly_ff[DLY-1][13:6], `JTL_TAG_D, smp_dly_ff[DLY-1][5:0], 2'h0};
    end
  end

  // Buffer in front of the lane absorbs a receiver stall.
  jtl_lane_buf #(
    .W(`JTL_LANE_W),
    .DEPTH(`JTL_BUF_DEPTH)
  ) jtl_lane_buf_i (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_data_in(buf_word),
    .in_valid_in(buf_valid),
    .in_ready_out(buf_ready),
    .out_data_out(lane_word_out),
    .out_valid_out(lane_valid_out),
    .out_ready_in(lane_ready_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks and the counters that only they read.
  localparam int LAT = `JTL_LANE_LAT;
  logic [15:0] since_sync_ff; // Clocks since the request went low.
  logic [15:0] since_ref_ff; // Clocks since SYSREF rose.
  logic [15:0] idle_ff; // Clocks in wake-up after all modes released.
  logic [7:0] run_ff; // Clocks of uninterrupted data flow.
  logic [15:0] wake_lim_ff; // Wake-up allowance of the mode held last.

  // Allowance follows the same priority as the wake-up timer, so each mode is judged by its own time.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wake_lim_ff <= 16'h0000;
    end
    else if (pin_s2_ff[2])
    begin
      wake_lim_ff <= 16'(WAKE_ADC_CYC);
    end
    else if (pin_s2_ff[0])
    begin
      wake_lim_ff <= 16'(`JTL_WAKE_OUT_CYC);
    end
    else if (pin_s2_ff[1])
    begin
      wake_lim_ff <= 16'(`JTL_WAKE_STBY_CYC);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      since_sync_ff <= 16'h0000;
      since_ref_ff <= 16'h0000;
      idle_ff <= 16'h0000;
      run_ff <= 8'h00;
    end
    else
    begin
      since_sync_ff <= (sync_prev_ff && !sync_n_s) ? 16'h0000 : since_sync_ff + 16'(since_sync_ff != 16'hffff);
      since_ref_ff <= sysref_rise ? 16'h0000 : since_ref_ff + 16'(since_ref_ff != 16'hffff);
      idle_ff <= (state_ff == jtl_pkg::JTL_ST_WAKE && !any_pd) ? idle_ff + 16'h0001 : 16'h0000;
      run_ff <= (adv && lane_ready_in && sample_valid_in && state_ff == jtl_pkg::JTL_ST_DATA)
                ? run_ff + 8'(run_ff != 8'hff) : 8'h00;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_cgs_enter;
    $past(state_ff) != jtl_pkg::JTL_ST_CGS && state_ff == jtl_pkg::JTL_ST_CGS;
  endsequence

  property p_sub0_delay;
    s_cgs_enter and !subclass1_in |-> since_sync_ff >= 16'(`JTL_SUB0_DELAY_MF * MF);
  endproperty
  a_sub0_delay: assert property (p_sub0_delay) else $error("K.28 came too soon after sync request");

  property p_sub1_delay;
    s_cgs_enter and subclass1_in |-> since_ref_ff >= 16'(`JTL_SUB1_DELAY_MF * MF);
  endproperty
  a_sub1_delay: assert property (p_sub1_delay) else $error("K.28 came too soon after SYSREF");

  property p_cgs_len;
    s_cgs_enter ##1 (state_ff == jtl_pkg::JTL_ST_CGS) |-> (state_ff == jtl_pkg::JTL_ST_CGS)[*8] or any_pd;
  endproperty
  a_cgs_len: assert property (p_cgs_len) else $error("code group sync ended early");

  property p_cgs_exit;
    $past(state_ff) == jtl_pkg::JTL_ST_CGS && state_ff == jtl_pkg::JTL_ST_DATA |-> $past(phase_cnt_ff) >= 16'(MF - 1);
  endproperty
  a_cgs_exit: assert property (p_cgs_exit) else $error("code group sync shorter than a multiframe");

  property p_lane_lat;
    run_ff >= 8'(LAT + 1) && lane_valid_out |-> lane_word_out[17:10] == $past(sample_in[13:6], LAT);
  endproperty
  a_lane_lat: assert property (p_lane_lat) else $error("lane latency is not 36 cycles");

  property p_fd_lat;
    fd_out == $past(fd_in, `JTL_FD_LAT);
  endproperty
  a_fd_lat: assert property (p_fd_lat) else $error("fast detect latency is not 7 cycles");

  property p_adc_wake;
    idle_ff <= wake_lim_ff + 16'h0001;
  endproperty
  a_adc_wake: assert property (p_adc_wake) else $error("wake-up took too long");

  property p_stby_wake;
    $fell(pin_s2_ff[1]) && !pin_s2_ff[2] && !pin_s2_ff[0] |-> ##[1:600] state_ff == jtl_pkg::JTL_ST_SYNC or any_pd;
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("standby wake-up took too long");

  property p_out_wake;
    $fell(pin_s2_ff[0]) && !pin_s2_ff[2] |-> ##1 wake_cnt_ff <= 16'(`JTL_WAKE_OUT_CYC);
  endproperty
  a_out_wake: assert property (p_out_wake) else $error("output wake-up count wrong");

endmodule
`default_nettype wire

// >>> hw/jtl_cfg.svh
// Constants for the converter's serial link timing and alignment block.
`ifndef JTL_CFG_SVH
`define JTL_CFG_SVH

// Sample clock rate in MHz; one frame of one sample per clock.
`define JTL_CLK_MHZ 50
// Line bits carried per converted sample.
`define JTL_UI_PER_SAMPLE 20
// Width of one line symbol and of one lane word.
`define JTL_SYM_W 10
`define JTL_LANE_W 20
// Converter sample width.
`define JTL_SMP_W 14
// Frames (sample clocks) per multiframe.
`define JTL_MF_CYC 32
// Multiframes from a sync request edge or a SYSREF edge to the first K.28 word.
`define JTL_SUB0_DELAY_MF 5
`define JTL_SUB1_DELAY_MF 6
// Least length of the code group synchronization phase in multiframes.
`define JTL_CGS_MIN_MF 1
// Pipeline latencies in sample clocks.
`define JTL_LANE_LAT 36
`define JTL_FD_LAT 7
// Wake-up times in microseconds.
`define JTL_WAKE_ADC_US 250
`define JTL_WAKE_STBY_US 10
`define JTL_WAKE_OUT_US 50
// Derived wake-up counts in clocks.
`define JTL_WAKE_STBY_CYC (`JTL_WAKE_STBY_US * `JTL_CLK_MHZ)
`define JTL_WAKE_OUT_CYC (`JTL_WAKE_OUT_US * `JTL_CLK_MHZ)
// Control octet of the K.28 synchronization character.
`define JTL_K28_OCTET 8'hbc
// Symbol tag bits: control flag and spare bit.
`define JTL_TAG_K 2'h2
`define JTL_TAG_D 2'h0
// Depth of the lane output buffer.
`define JTL_BUF_DEPTH 2
// Number of synchronised pins.
`define JTL_PIN_N 5

`endif

// >>> hw/jtl_pkg.sv
// Types shared by the link timing block.
package jtl_pkg;

  // Link states, one-hot.
  typedef enum logic [4:0] {
    JTL_ST_WAKE  = 5'h01,
    JTL_ST_SYNC  = 5'h02,
    JTL_ST_DELAY = 5'h04,
    JTL_ST_CGS   = 5'h08,
    JTL_ST_DATA  = 5'h10
  } jtl_state_t;

endpackage

// >>> hw/jtl_lane_buf.sv
// Small FIFO that holds lane words while the receiver stalls.
`timescale 1ns/10ps
`default_nettype none
`include "jtl_cfg.svh"

module jtl_lane_buf #(
  parameter int W = `JTL_LANE_W,
  parameter int DEPTH = `JTL_BUF_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage, pointers and fill count.
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so they never lie.
  assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out = mem_ff[rd_ptr_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  ////////////////////////////////////////////////////////////////////////
  // Word storage; data words need no reset.
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // Pointers wrap at the depth.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
      end
    end
  end

  // Fill count follows pushes and pops.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= '0;
    end
    else if (push && !pop)
    begin
      cnt_ff <= cnt_ff + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      cnt_ff <= cnt_ff - (AW+1)'(1);
    end
  end

endmodule
`default_nettype wire

// >>> dv/jtl_rx_model.sv
// Receiver model for the serial lane: sync request and word capture.
`timescale 1ns/10ps
`default_nettype none
`include "jtl_cfg.svh"

module jtl_rx_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic hold_in,
  input wire logic early_in,
  input wire logic stall_in,
  input wire logic [`JTL_LANE_W-1:0] lane_word_in,
  input wire logic lane_valid_in,
  output logic lane_ready_out,
  output logic sync_req_n_out
);
  // K words taken since the last sync start.
  int k_cnt;
  // Data words taken, oldest first.
  logic [`JTL_LANE_W-1:0] dq[$];

  ////////////////////////////////////////
  // Capture words; the ready line follows the stall request one clock late.
  always @(posedge clk_in)
  begin
    lane_ready_out <= !stall_in;
    if (!rst_in && lane_valid_in && lane_ready_out)
    begin
      // A K word counts towards the sync phase, anything else is data.
      if (lane_word_in === {`JTL_TAG_K, `JTL_K28_OCTET, `JTL_TAG_K, `JTL_K28_OCTET})
        k_cnt <= k_cnt + 1;
      else
        dq.push_back(lane_word_in);
    end
    // The request stays low through wake-up and delay, until K words arrive.
    if (rst_in)
    begin
      sync_req_n_out <= 1'h1;
      k_cnt <= 0;
    end
    else if (start_in)
    begin
      sync_req_n_out <= 1'h0;
      k_cnt <= 0;
    end
    else if (!sync_req_n_out && !hold_in && k_cnt >= (early_in ? 1 : `JTL_MF_CYC))
      sync_req_n_out <= 1'h1;
  end
endmodule
`default_nettype wire

// >>> dv/tb_jtl_link_timing.sv
// Testbench for the serial lane sequencer with a receiver model.
`timescale 1ns/10ps
`default_nettype none
`include "jtl_cfg.svh"

module tb_jtl_link_timing;
  // Stimulus and observed signals.
  logic clk_in = 1'h0, rst_in = 1'h1, sub1 = 1'h0, sysref = 1'h0;
  logic pd_adc = 1'h0, pd_out = 1'h0, stby = 1'h0, smp_v = 1'h0, fd = 1'h0;
  logic start = 1'h0, hold = 1'h0, early = 1'h0, stall = 1'h0;
  logic [13:0] smp = 14'h0000;
  logic smp_rdy, fd_o, lv, lr, len, act, req_n;
  logic [19:0] lw;
  // Counters for the verdict and the hang guard.
  int n_errors = 0, n_tests = 0, cyc = 0;

  jtl_link_timing #(.WAKE_ADC_CYC(50)) jtl_link_timing_i (.clk_in(clk_in), .rst_in(rst_in),
    .subclass1_in(sub1), .link_sync_request_n_in(req_n), .sysref_in(sysref),
    .adc_powerdown_in(pd_adc), .standby_in(stby), .output_powerdown_in(pd_out),
    .sample_in(smp), .sample_valid_in(smp_v), .sample_ready_out(smp_rdy), .fd_in(fd),
    .fd_out(fd_o), .lane_word_out(lw), .lane_valid_out(lv), .lane_ready_in(lr),
    .lane_enable_out(len), .link_active_out(act));
  jtl_rx_model jtl_rx_model_i (.clk_in(clk_in), .rst_in(rst_in), .start_in(start),
    .hold_in(hold), .early_in(early), .stall_in(stall), .lane_word_in(lw),
    .lane_valid_in(lv), .lane_ready_out(lr), .sync_req_n_out(req_n));

  ////////////////////////////////////////
  // Clock of 20 ns and a hang guard well above the expected run.
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////
  // Compare and count.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Expected data word of one sample.
  function automatic logic [19:0] dword(input logic [13:0] s);
    return {`JTL_TAG_D, s[13:6], `JTL_TAG_D, s[5:0], 2'h0};
  endfunction

  // Reset for three clocks with the chosen subclass.
  task automatic do_reset(input logic s1);
    @(posedge clk_in);
    sub1 <= s1;
    rst_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
  endtask

  // One-clock pulse asking the receiver to start a sync.
  task automatic pulse_start();
    @(posedge clk_in);
    start <= 1'h1;
    @(posedge clk_in);
    start <= 1'h0;
  endtask

  // Count clocks until the first K word is taken.
  task automatic wait_k(output int t);
    t = 0;
    @(negedge clk_in);
    while (jtl_rx_model_i.k_cnt == 0 && t < 3000)
    begin
      @(negedge clk_in);
      t++;
    end
  endtask

  // Wait, bounded, for the data state.
  task automatic wait_act();
    int t;
    t = 0;
    while (act !== 1'h1 && t < 300)
    begin
      @(negedge clk_in);
      t++;
    end
    check(act, 1'h1);
  endtask

  ////////////////////////////////////////
  // Subclass 0 with an early release: delay and full K phase still kept.
  task automatic t_sub0();
    int t;
    do_reset(1'h0);
    early <= 1'h1;
    pulse_start();
    while (req_n !== 1'h0)
      @(negedge clk_in);
    wait_k(t);
    check(t >= 5 * `JTL_MF_CYC, 1);
    check(t <= 175, 1);
    wait_act();
    repeat (4) @(posedge clk_in);
    check(jtl_rx_model_i.k_cnt >= `JTL_MF_CYC, 1);
    early <= 1'h0;
    $display("test subclass 0 done");
  endtask

  // Subclass 1: K words no sooner than six multiframes after the reference edge.
  task automatic t_sub1();
    int t;
    do_reset(1'h1);
    pulse_start();
    repeat (5) @(posedge clk_in);
    sysref <= 1'h1;
    @(posedge clk_in);
    sysref <= 1'h0;
    wait_k(t);
    check(t + 1 >= 6 * `JTL_MF_CYC, 1);
    check(t <= 210, 1);
    wait_act();
    $display("test subclass 1 done");
  endtask

  // Lane and fast detect latencies, and the twenty-bit word layout.
  task automatic t_lat();
    int tf, tl;
    tf = -1;
    tl = -1;
    @(posedge clk_in);
    smp <= 14'h2a5c;
    smp_v <= 1'h1;
    fd <= 1'h1;
    for (int k = 0; k < 60; k++)
    begin
      @(negedge clk_in);
      if (fd_o === 1'h1 && tf < 0)
        tf = k;
      if (lv === 1'h1 && lw === dword(14'h2a5c) && tl < 0)
        tl = k;
      @(posedge clk_in);
      smp <= {6'(k), 8'h00};
      fd <= 1'h0;
    end
    smp_v <= 1'h0;
    repeat (40) @(posedge clk_in);
    check(tf, 7);
    check(tl, 36);
    $display("test latency done");
  endtask

  // Receiver stall: input refused when full, then every word delivered in order.
  task automatic t_stall();
    int n, t;
    logic low;
    n = 0;
    low = 1'h0;
    jtl_rx_model_i.dq.delete();
    @(posedge clk_in);
    stall <= 1'h1;
    for (int k = 0; k < 80; k++)
    begin
      @(posedge clk_in);
      smp <= 14'h1000 + 14'(n);
      smp_v <= 1'h1;
      @(negedge clk_in);
      if (smp_rdy === 1'h1)
        n++;
      else
        low = 1'h1;
    end
    @(posedge clk_in);
    smp_v <= 1'h0;
    stall <= 1'h0;
    check(low, 1'h1);
    t = 0;
    while (jtl_rx_model_i.dq.size() < n && t < 300)
    begin
      @(negedge clk_in);
      t++;
    end
    check(jtl_rx_model_i.dq.size(), n);
    for (int i = 0; i < n && jtl_rx_model_i.dq.size() > 0; i++)
      check(jtl_rx_model_i.dq.pop_front(), dword(14'h1000 + 14'(i)));
    $display("test stall done");
  endtask

  // Power modes in turn: ADC, output, standby; wake time bounded.
  task automatic t_power();
    int t;
    int w[3] = '{50, 2500, 500};
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk_in);
      hold <= 1'h1;
      {pd_adc, pd_out, stby} <= 3'h4 >> m;
      repeat (5) @(posedge clk_in);
      check(len, m != 1);
      check(act, 1'h0);
      pulse_start();
      repeat (20) @(posedge clk_in);
      {pd_adc, pd_out, stby} <= 3'h0;
      wait_k(t);
      check(t >= w[m], 1);
      check(t <= w[m] + 5 * `JTL_MF_CYC + 20, 1);
      hold <= 1'h0;
      wait_act();
      check(len, 1'h1);
    end
    $display("test power modes done");
  endtask

  ////////////////////////////////////////
  // Main sequence.
  initial
  begin
    t_sub0();
    t_lat();
    t_stall();
    t_power();
    t_sub1();
    t_lat();
    give_verdict();
  end
endmodule
`default_nettype wire
